/* File: ubpg_top.v */
// burst pulse generator with its axi4-lite register slave
// Behaviour
// - a pulse count of zero disables the generator, 1 to 127 gives exactly that many pulses.
// - with start routing set the burst's first edge is passed to the time measurement start.
// - idle outputs float when the idle select is zero and are driven low when it is one.
// - bursts of up to 15 pulses take their phase from pattern bits 0 to 14; software keeps bit 15 zero.
// - a phase bit of zero gives high then low, a one gives low then high.
// - the first pulse uses the lowest pattern bit and later pulses step upward.
// - the base clock is the high-speed clock divided by the selected divider.
// - the base clock is doubled and divided by divider plus one; software never writes zero.
// - bit 19 of the output configuration turns the dither phase shift off when one.
// - each pulse lasts at least two reference periods, one high and one low.
// - with bit 31 both outputs fire together, downstream the inverse of upstream.
// - with bit 30 only upstream fires, or upstream fires first on a restart command.
// - with bit 29 only downstream fires, or downstream fires first on a restart command.
// - a burst begins only on a start or a restart command.
`timescale 1ns/1ps
`include "ubpg_regs.vh"
module ubpg_top (
  aclk,
  aresetn,
  s_axi_awaddr,
  s_axi_awvalid,
  s_axi_awready,
  s_axi_wdata,
  s_axi_wstrb,
  s_axi_wvalid,
  s_axi_wready,
  s_axi_bresp,
  s_axi_bvalid,
  s_axi_bready,
  s_axi_araddr,
  s_axi_arvalid,
  s_axi_arready,
  s_axi_rdata,
  s_axi_rresp,
  s_axi_rvalid,
  s_axi_rready,
  fire_up_o,
  fire_up_oe_n,
  fire_down_o,
  fire_down_oe_n,
  tdc_start_o
);
  input wire aclk;
  input wire aresetn;
  input wire [3:0] s_axi_awaddr;
  input wire s_axi_awvalid;
  output wire s_axi_awready;
  input wire [31:0] s_axi_wdata;
  input wire [3:0] s_axi_wstrb;
  input wire s_axi_wvalid;
  output wire s_axi_wready;
  output reg [1:0] s_axi_bresp;
  output reg s_axi_bvalid;
  input wire s_axi_bready;
  input wire [3:0] s_axi_araddr;
  input wire s_axi_arvalid;
  output wire s_axi_arready;
  output reg [31:0] s_axi_rdata;
  output reg [1:0] s_axi_rresp;
  output reg s_axi_rvalid;
  input wire s_axi_rready;
  output reg fire_up_o;
  output reg fire_up_oe_n;
  output reg fire_down_o;
  output reg fire_down_oe_n;
  output reg tdc_start_o;

  localparam ST_IDLE = 2'd0;
  localparam ST_DELAY = 2'd1;
  localparam ST_RUN = 2'd2;

  reg [31:0] ctrl_q;
  reg [31:0] outcfg_q;
  reg aw_held_q;
  reg [3:0] awaddr_q;
  reg w_held_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg [1:0] state_q;
  reg [6:0] pulse_idx_q;
  reg half_q;
  reg [1:0] delay_q;
  reg down_first_q;
  reg alt_next_down_q;
  reg restart_q;
  reg run_q;
  reg cmd_start;
  reg cmd_restart;

  wire ref_tick;
  wire [1:0] rnd;
  wire [6:0] burst_pulse_count = ctrl_q[`UBPG_CTRL_CNT_MSB:`UBPG_CTRL_CNT_LSB];
  wire start_route = ctrl_q[`UBPG_CTRL_ROUTE];
  wire idle_gnd = ctrl_q[`UBPG_CTRL_IDLE];
  wire [15:0] pulse_phase_pattern = outcfg_q[`UBPG_OUT_PHASE_MSB:0];
  wire phase_dither_off = outcfg_q[`UBPG_OUT_DITHER_OFF];
  wire cfg_both = outcfg_q[`UBPG_OUT_BOTH];
  wire cfg_up = outcfg_q[`UBPG_OUT_UP];
  wire cfg_down = outcfg_q[`UBPG_OUT_DOWN];
  wire wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;

  // byte-lane merge of a write into a stored register
  function [31:0] merge;
    input [31:0] old;
    input [31:0] data;
    input [3:0] strb;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          merge[i*8 +: 8] = data[i*8 +: 8];
        end
      end
    end
  endfunction

  ubpg_refgen u_refgen (
    .aclk(aclk),
    .aresetn(aresetn),
    .hs_clock_divider(ctrl_q[`UBPG_CTRL_HSDIV_MSB:`UBPG_CTRL_HSDIV_LSB]),
    .burst_divider(ctrl_q[`UBPG_CTRL_BDIV_MSB:`UBPG_CTRL_BDIV_LSB]),
    .ref_tick(ref_tick)
  );

  ubpg_lfsr u_lfsr (
    .aclk(aclk),
    .aresetn(aresetn),
    .rnd(rnd)
  );

  // write channels are taken independently and held until both are present
  assign s_axi_awready = !aw_held_q;
  assign s_axi_wready = !w_held_q;
  assign s_axi_arready = !s_axi_rvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 4'h0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `UBPG_RESP_OKAY;
      ctrl_q <= `UBPG_CTRL_RESET;
      outcfg_q <= `UBPG_OUTCFG_RESET;
    end else begin
      if (s_axi_awvalid && !aw_held_q) begin
        aw_held_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held_q) begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `UBPG_RESP_OKAY;
        case (awaddr_q)
          `UBPG_ADDR_CTRL: ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q);
          `UBPG_ADDR_OUTCFG: outcfg_q <= merge(outcfg_q, wdata_q, wstrb_q);
          `UBPG_ADDR_CMD: ;
          `UBPG_ADDR_STATUS: ;
          default: s_axi_bresp <= `UBPG_RESP_SLVERR;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // command strobes come from a write to the command register with lane 0 enabled
  always @* begin
    cmd_start = wr_fire && awaddr_q == `UBPG_ADDR_CMD && wstrb_q[0] && wdata_q[`UBPG_CMD_START];
    cmd_restart = wr_fire && awaddr_q == `UBPG_ADDR_CMD && wstrb_q[0] && wdata_q[`UBPG_CMD_RESTART];
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `UBPG_RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `UBPG_RESP_OKAY;
      case (s_axi_araddr)
        `UBPG_ADDR_CTRL: s_axi_rdata <= ctrl_q;
        `UBPG_ADDR_OUTCFG: s_axi_rdata <= outcfg_q;
        `UBPG_ADDR_CMD: s_axi_rdata <= 32'h0000_0000;
        `UBPG_ADDR_STATUS: s_axi_rdata <= {16'h0000, 1'b0, pulse_idx_q, 5'h00, alt_next_down_q, down_first_q,
                                           state_q != ST_IDLE};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `UBPG_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // burst sequencer; commands while busy or with a zero count are dropped
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_IDLE;
      pulse_idx_q <= 7'd0;
      half_q <= 1'b0;
      delay_q <= 2'd0;
      down_first_q <= 1'b0;
      alt_next_down_q <= 1'b0;
      restart_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if ((cmd_start || cmd_restart) && burst_pulse_count != 7'd0) begin
            pulse_idx_q <= 7'd0;
            half_q <= 1'b0;
            // dither delays the burst by a random number of reference periods
            delay_q <= phase_dither_off ? 2'd0 : rnd;
            state_q <= ST_DELAY;
            // the first restart fires the configured side, later restarts alternate
            if (cmd_restart) begin
              down_first_q <= restart_q ? alt_next_down_q : cfg_down;
              alt_next_down_q <= restart_q ? !alt_next_down_q : !cfg_down;
            end else begin
              down_first_q <= cfg_down;
              alt_next_down_q <= !cfg_up;
            end
            restart_q <= cmd_restart;
          end else if (!cmd_restart && !cmd_start) begin
            alt_next_down_q <= alt_next_down_q;
          end
        end
        ST_DELAY: begin
          if (ref_tick) begin
            if (delay_q == 2'd0) begin
              state_q <= ST_RUN;
            end else begin
              delay_q <= delay_q - 2'd1;
            end
          end
        end
        ST_RUN: begin
          if (ref_tick) begin
            half_q <= !half_q;
            if (half_q) begin
              if (pulse_idx_q == burst_pulse_count - 7'd1) begin
                state_q <= ST_IDLE;
              end
              pulse_idx_q <= pulse_idx_q + 7'd1;
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  reg phase_bit;
  reg wave;
  reg up_en;
  reg dn_en;
  always @* begin
    // long bursts carry no per-pulse phase
    phase_bit = (burst_pulse_count <= `UBPG_PHASE_PULSES) ? pulse_phase_pattern[pulse_idx_q[3:0]] : 1'b0;
    wave = half_q ^ !phase_bit;
    up_en = cfg_both || (restart_q ? !down_first_q : cfg_up);
    dn_en = cfg_both || (restart_q ? down_first_q : cfg_down);
    if (!cfg_both && cfg_up == cfg_down) begin
      up_en = !down_first_q;
      dn_en = down_first_q;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      fire_up_o <= 1'b0;
      fire_up_oe_n <= 1'b1;
      fire_down_o <= 1'b0;
      fire_down_oe_n <= 1'b1;
      tdc_start_o <= 1'b0;
      run_q <= 1'b0;
    end else begin
      fire_up_o <= (state_q == ST_RUN && up_en) ? wave : 1'b0;
      fire_up_oe_n <= (state_q == ST_RUN && up_en) ? 1'b0 : !idle_gnd;
      fire_down_o <= (state_q == ST_RUN && dn_en) ? (cfg_both ? !wave : wave) : 1'b0;
      fire_down_oe_n <= (state_q == ST_RUN && dn_en) ? 1'b0 : !idle_gnd;
      // keyed to entry into run, so a slow reference still gives a one-cycle start
      run_q <= state_q == ST_RUN;
      tdc_start_o <= start_route && state_q == ST_RUN && !run_q;
    end
  end
endmodule

/* File: ubpg_regs.vh */
// register map, field positions and reset values of the burst pulse generator
`ifndef UBPG_REGS_VH
`define UBPG_REGS_VH
`define UBPG_ADDR_CTRL 4'h0
`define UBPG_ADDR_OUTCFG 4'h4
`define UBPG_ADDR_CMD 4'h8
`define UBPG_ADDR_STATUS 4'hC
`define UBPG_CTRL_CNT_LSB 0
`define UBPG_CTRL_CNT_MSB 6
`define UBPG_CTRL_ROUTE 7
`define UBPG_CTRL_IDLE 8
`define UBPG_CTRL_HSDIV_LSB 12
`define UBPG_CTRL_HSDIV_MSB 13
`define UBPG_CTRL_BDIV_LSB 20
`define UBPG_CTRL_BDIV_MSB 23
`define UBPG_CTRL_RESET 32'h0010_0000
`define UBPG_OUT_PHASE_MSB 15
`define UBPG_OUT_REPEAT_LSB 16
`define UBPG_OUT_REPEAT_MSB 18
`define UBPG_OUT_DITHER_OFF 19
`define UBPG_OUT_BOTH 31
`define UBPG_OUT_UP 30
`define UBPG_OUT_DOWN 29
`define UBPG_OUTCFG_RESET 32'h8008_0000
`define UBPG_CMD_START 0
`define UBPG_CMD_RESTART 1
`define UBPG_PHASE_PULSES 7'd15
`define UBPG_MAX_DELAY 2
`define UBPG_RESP_OKAY 2'b00
`define UBPG_RESP_SLVERR 2'b10
`endif

/* File: ubpg_refgen.v */
// reference tick generator: base clock from the high-speed divider, doubled, divided again
`timescale 1ns/1ps
module ubpg_refgen (
  aclk,
  aresetn,
  hs_clock_divider,
  burst_divider,
  ref_tick
);
  input wire aclk;
  input wire aresetn;
  input wire [1:0] hs_clock_divider;
  input wire [3:0] burst_divider;
  output reg ref_tick;

  reg [7:0] acc_q;
  reg [7:0] period;
  reg [7:0] sum;

  // one ref period = (div+1) half periods of the base clock, in aclk cycles times two;
  // the accumulator keeps the average rate exact when the ratio is odd
  always @* begin
    case (hs_clock_divider)
      2'd0: period = {4'h0, burst_divider} + 8'h01;
      2'd1: period = {3'h0, burst_divider, 1'b0} + 8'h02;
      default: period = {2'h0, burst_divider, 2'b00} + 8'h04;
    endcase
    sum = acc_q + 8'h02;
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      acc_q <= 8'h00;
      ref_tick <= 1'b0;
    end else if (sum >= period) begin
      acc_q <= sum - period;
      ref_tick <= 1'b1;
    end else begin
      acc_q <= sum;
      ref_tick <= 1'b0;
    end
  end
endmodule

/* File: ubpg_lfsr.v */
// free running pseudo random source for the phase shift dither
`timescale 1ns/1ps
module ubpg_lfsr (
  aclk,
  aresetn,
  rnd
);
  input wire aclk;
  input wire aresetn;
  output wire [1:0] rnd;

  reg [15:0] lfsr_q;

  always @(posedge aclk) begin
    if (!aresetn) begin
      lfsr_q <= 16'hACE1;
    end else begin
      lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    end
  end

  assign rnd = lfsr_q[1:0];
endmodule

/* File: ubpg_asserts.sv */
// concurrent checks on the burst generator's bus handshakes and drive pins
`timescale 1ns/1ps
module ubpg_asserts (
  input logic aclk,
  input logic aresetn,
  input logic [3:0] s_axi_awaddr,
  input logic s_axi_awvalid,
  input logic s_axi_awready,
  input logic s_axi_wvalid,
  input logic s_axi_wready,
  input logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic s_axi_rvalid,
  input logic s_axi_rready,
  input logic fire_up_o,
  input logic fire_up_oe_n,
  input logic fire_down_oe_n,
  input logic tdc_start_o
);
  logic cmd_seen_q;
  // weak on purpose: only proves that no upstream pulse leaves before any command was ever sent
  always @(posedge aclk) begin
    if (!aresetn) begin
      cmd_seen_q <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready && s_axi_awaddr == 4'h8) begin
      cmd_seen_q <= 1'b1;
    end
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_ar_ready_free: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("arready is not the inverse of rvalid");
  a_read_answer_next: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer did not follow the address");
  a_read_data_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped or changed before rready");
  a_write_answer_next: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer did not follow address and data");
  a_write_resp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped before bready");
  a_addr_held_blocks: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("second address accepted while one is held");
  a_tdc_single_pulse: assert property (tdc_start_o |=> !tdc_start_o)
    else $error("measurement start pulse longer than one cycle");
  a_reset_idle_float: assert property ($rose(aresetn) |-> fire_up_oe_n && fire_down_oe_n && !tdc_start_o)
    else $error("outputs not floating after reset");
  a_fire_needs_cmd: assert property ($rose(fire_up_o) |-> cmd_seen_q)
    else $error("pulse emitted before any command");
endmodule
bind ubpg_top ubpg_asserts chk_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .fire_up_o(fire_up_o),
  .fire_up_oe_n(fire_up_oe_n), .fire_down_oe_n(fire_down_oe_n), .tdc_start_o(tdc_start_o));

/* File: ubpg_xdcr_model.sv */
// transducer behind series r and c: counts driven pulses and the burst span
`timescale 1ns/1ps
module ubpg_xdcr_model (
  input logic aclk,
  input logic drv,
  input logic oe_n,
  input logic clr,
  output int rises,
  output int span,
  output logic pin
);
  int cyc = 0;
  int t0 = 0;
  logic pv = 1'b0;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (clr) begin
      rises <= 0;
      span <= 0;
      pv <= 1'b0;
    end else if (!oe_n) begin
      pv <= drv;
      if (drv && !pv) begin
        rises <= rises + 1;
        if (rises == 0) t0 <= cyc;
      end
      if (!drv && pv) span <= cyc - t0;
    end
  end
  // the series capacitor gives no dc path, so a released line floats: show the inverse
  assign pin = oe_n ? ~pv : drv;
endmodule

/* File: ubpg_top_tb.sv */
// self-checking bench for the burst pulse generator
`timescale 1ns/1ps
`include "ubpg_regs.vh"
module ubpg_top_tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [3:0] s_axi_araddr = 4'h0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic clr = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [31:0] rd_q;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire fire_up_o, fire_up_oe_n, fire_down_o, fire_down_oe_n, tdc_start_o;
  int miscompares = 0;
  int checks = 0;
  int up_n, up_span, dn_n, tdc_n, same_hi;
  int cn[3] = '{1, 15, 127};
  int dv[3] = '{1, 3, 7};
  int pat[4] = '{1, 2, 3, 6};
  int pexp[4] = '{1, 2, 2, 3};
  // exactly one drive select bit per entry, repeat field left at zero
  logic [31:0] sel[4] = '{32'h4008_0000, 32'h2008_0000, 32'h4008_0000, 32'h4008_0000};
  always #10 aclk = ~aclk;
  ubpg_top dut_u (.*);
  ubpg_xdcr_model up_u (.aclk(aclk), .drv(fire_up_o), .oe_n(fire_up_oe_n), .clr(clr), .rises(up_n),
    .span(up_span), .pin());
  ubpg_xdcr_model dn_u (.aclk(aclk), .drv(fire_down_o), .oe_n(fire_down_oe_n), .clr(clr), .rises(dn_n),
    .span(), .pin());
  always @(posedge aclk) begin
    if (clr) begin
      tdc_n <= 0;
      same_hi <= 0;
    end else begin
      tdc_n <= tdc_n + int'(tdc_start_o);
      same_hi <= same_hi + int'(!fire_up_oe_n && !fire_down_oe_n && fire_up_o && fire_down_o);
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b0;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      // ready comes one cycle late so the held answer is exercised
      if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'b1;
    end while (!(s_axi_bvalid && s_axi_bready));
    chk(32'(s_axi_bresp), 32'(`UBPG_RESP_OKAY));
  endtask
  task automatic rd(input logic [3:0] a, input logic [1:0] resp);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b0;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
    end while (!(s_axi_rvalid && s_axi_rready));
    rd_q = s_axi_rdata;
    chk(32'(s_axi_rresp), 32'(resp));
  endtask
  // negative downstream count and span expectations are skipped
  task automatic burst(input logic [31:0] ctrl, input logic [31:0] cfg, input logic [31:0] cmd, input int eu,
    input int ed, input int sp, input int et, input int again);
    wr(`UBPG_ADDR_CTRL, ctrl);
    wr(`UBPG_ADDR_OUTCFG, cfg);
    clr <= 1'b1;
    @(posedge aclk);
    clr <= 1'b0;
    wr(`UBPG_ADDR_CMD, cmd);
    if (again != 0) wr(`UBPG_ADDR_CMD, cmd);
    repeat (4) @(posedge aclk);
    do rd(`UBPG_ADDR_STATUS, `UBPG_RESP_OKAY); while (rd_q[0]);
    chk(up_n, eu);
    if (ed >= 0) chk(dn_n, ed);
    if (sp >= 0) chk(up_span, sp);
    chk(tdc_n, et);
    chk(same_hi, 0);
    chk({fire_up_o, fire_down_o}, 2'b00);
    if (cfg[31]) chk({fire_up_oe_n, fire_down_oe_n}, ctrl[8] ? 2'b00 : 2'b11);
  endtask
  task wrap_up;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #1_000_000;
    miscompares++;
    wrap_up;
  end
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`UBPG_ADDR_CTRL, `UBPG_RESP_OKAY);
    chk(rd_q, `UBPG_CTRL_RESET);
    rd(`UBPG_ADDR_OUTCFG, `UBPG_RESP_OKAY);
    chk(rd_q, `UBPG_OUTCFG_RESET);
    rd(4'h2, `UBPG_RESP_SLVERR);
    chk(rd_q, 32'h0000_0000);
    burst(32'h0010_0105, 32'h8008_0000, 32'h0, 0, 0, -1, 0, 0);
    burst(32'h0010_0100, 32'h8008_0000, 32'h1, 0, 0, -1, 0, 0);
    // rate table: reference period is (divider + 1) * hs division / 2 cycles
    for (int i = 0; i < 3; i++) begin
      burst(cn[i] | (int'(i == 0) << 7) | (int'(i != 1) << 8) | (i << 12) | (dv[i] << 20),
        i == 1 ? 32'h8000_0000 : 32'h8008_0000, 32'h1, cn[i], cn[i],
        (2 * cn[i] - 1) * (dv[i] + 1) * (1 << i) / 2, int'(i == 0), int'(i == 1));
    end
    for (int j = 0; j < 4; j++) begin
      burst(32'h0010_0100 | (2 + j / 2), 32'h8008_0000 | pat[j], 32'h1, pexp[j], -1, -1, 0, 0);
    end
    for (int k = 0; k < 4; k++) begin
      burst(32'h0010_0103, sel[k], k < 2 ? 32'h1 : 32'h2, k[0] ? 0 : 3, k[0] ? 3 : 0, -1, 0, 0);
    end
    wrap_up;
  end
endmodule
